// file: logic/pec_pkg.sv
// Package for the performance event generator: carriers, event indices and widths
package pec_pkg;

    localparam int SLOTS      = 4;
    localparam int CNT_W      = 3;
    localparam int FLOW_W     = 3;
    localparam int FLOW_SUM_W = 5;
    localparam int HOLD_W     = 3;

    // Per-slot commit counters
    localparam int C_SIMD_FP       = 0;
    localparam int C_SIMD_FMA      = 1;
    localparam int C_PREFIX_ONE    = 2;
    localparam int C_PREFIX_TWO    = 3;
    localparam int C_UNPACK_ONE    = 4;
    localparam int C_UNPACK_TWO    = 5;
    localparam int C_INT_MAD       = 6;
    localparam int C_INT_LOAD      = 7;
    localparam int C_INT_STORE     = 8;
    localparam int C_FP_LOAD       = 9;
    localparam int C_FP_STORE      = 10;
    localparam int C_SIMD_FP_LOAD  = 11;
    localparam int C_SIMD_FP_STORE = 12;
    localparam int C_N             = 13;

    // Single-cycle events
    localparam int E_HOLD_EMPTY    = 0;
    localparam int E_HALT          = 1;
    localparam int E_FLUSH         = 2;
    localparam int E_SYNC_ILK      = 3;
    localparam int E_REGWIN_ILK    = 4;
    localparam int E_DECODE_ILK    = 5;
    localparam int E_FP_MIX_ILK    = 6;
    localparam int E_MEM_WAIT      = 7;
    localparam int E_MW_NONCACHE   = 8;
    localparam int E_MW_INT        = 9;
    localparam int E_MW_L2MISS     = 10;
    localparam int E_MW_L2MISS_INT = 11;
    localparam int E_MW_PORT_BUSY  = 12;
    localparam int E_MW_PORT_INT   = 13;
    localparam int E_MW_SW_PF      = 14;
    localparam int E_CSE_EMPTY     = 15;
    localparam int E_CSE_EMPTY_SPF = 16;
    localparam int E_EXEC_WAIT     = 17;
    localparam int E_BRANCH_WAIT   = 18;
    localparam int E_ISSUE0        = 19;
    localparam int E_TRAP_ALL      = 24;
    localparam int E_TRAP_VECTOR   = 25;
    localparam int E_TRAP_LEVEL    = 26;
    localparam int E_TRAP_SPILL    = 27;
    localparam int E_TRAP_FILL     = 28;
    localparam int E_TRAP_INST     = 29;
    localparam int E_TRAP_IMISS    = 30;
    localparam int E_TRAP_DMISS    = 31;
    localparam int E_TRAP_SIMD_PG  = 32;
    localparam int E_N             = 33;

    localparam logic [CNT_W-1:0] MAX_ISSUE = 3'h4;

    typedef struct packed {
        logic              valid;
        logic              simd;
        logic              fp_op;
        logic              fma_op;
        logic              prefix_form_one;
        logic              prefix_form_two;
        logic              unpacked;
        logic              int_multiply_add_low;
        logic              int_multiply_add_high;
        logic              int_load;
        logic              int_store;
        logic              atomic;
        logic              fp_load;
        logic              fp_store;
        logic              quad;
        logic [FLOW_W-1:0] flows;
    } pec_commit_slot_t;

    typedef struct packed {
        logic int_vector;
        logic int_level;
        logic spill_normal;
        logic spill_other;
        logic fill_normal;
        logic fill_other;
        logic trap_inst;
        logic immu_miss;
        logic dmmu_miss;
        logic simd_cross_page;
    } pec_trap_t;

    typedef struct packed {
        logic [HOLD_W-1:0] hold_entries;
        logic [CNT_W-1:0]  issue_cnt;
        logic              sync_ilk;
        logic              regwin_ilk;
        logic              other_static_ilk;
        logic              dynamic_stall;
        logic              fp_mix_ilk;
        logic [SLOTS-1:0]  pred_taken;
        logic [SLOTS-1:0]  is_branch;
        logic [SLOTS-1:0]  pred_valid;
    } pec_front_t;

    typedef struct packed {
        logic halt_trap;
        logic halt_priv_update;
        logic halt_mem_order;
        logic halt_hw_retry;
        logic mispredict_flush;
    } pec_ctrl_t;

    typedef struct packed {
        logic cse_empty;
        logic store_ports_full;
        logic is_mem;
        logic waiting_data;
        logic is_store;
        logic is_atomic;
        logic noncacheable;
        logic is_int;
        logic is_fp;
        logic is_branch;
        logic l2_miss;
        logic port_busy;
        logic sw_prefetch;
        logic strong_prefetch;
    } pec_oldest_t;

endpackage : pec_pkg

// file: logic/pec_event_gen.sv
// Performance event generator: per-cycle increment values for the counters
`timescale 1ns/1ps
`default_nettype none

module pec_event_gen (
    input  wire logic                                          clk,
    input  wire logic                                          resetn,
    input  wire pec_pkg::pec_commit_slot_t [pec_pkg::SLOTS-1:0] commit_slot,
    input  wire pec_pkg::pec_trap_t                            trap_taken,
    input  wire pec_pkg::pec_front_t                           front,
    input  wire pec_pkg::pec_ctrl_t                            ctrl,
    input  wire pec_pkg::pec_oldest_t                          oldest,
    output logic [pec_pkg::C_N-1:0][pec_pkg::CNT_W-1:0]       commit_inc,
    output logic [pec_pkg::FLOW_SUM_W-1:0]                     flow_inc,
    output logic [pec_pkg::CNT_W-1:0]                          phantom_inc,
    output logic [pec_pkg::E_N-1:0]                            event_hit
);

    logic [pec_pkg::SLOTS-1:0][pec_pkg::C_N-1:0] slot_hit;
    logic [pec_pkg::SLOTS-1:0][pec_pkg::FLOW_W-1:0] slot_flows;
    logic [pec_pkg::SLOTS-1:0]                     slot_phantom;

    logic [pec_pkg::C_N-1:0][pec_pkg::CNT_W-1:0]  commit_inc_d;
    logic [pec_pkg::C_N-1:0][pec_pkg::CNT_W-1:0]  commit_inc_q;
    logic [pec_pkg::FLOW_SUM_W-1:0]                flow_inc_d;
    logic [pec_pkg::FLOW_SUM_W-1:0]                flow_inc_q;
    logic [pec_pkg::CNT_W-1:0]                     phantom_inc_d;
    logic [pec_pkg::CNT_W-1:0]                     phantom_inc_q;
    logic [pec_pkg::E_N-1:0]                       event_d;
    logic [pec_pkg::E_N-1:0]                       event_q;

    logic no_commit;
    logic mem_wait;
    logic exec_wait;
    logic port_busy_wait;

    // Classify each commit and decode slot
    genvar g;
    generate
        for (g = 0; g < pec_pkg::SLOTS; g++) begin : g_slot
            pec_pkg::pec_commit_slot_t s;
            logic packed_prefix;
            assign s             = commit_slot[g];
            assign packed_prefix = (s.prefix_form_one | s.prefix_form_two) & ~s.unpacked;

            assign slot_hit[g][pec_pkg::C_SIMD_FP]      = s.valid & s.simd & s.fp_op;
            assign slot_hit[g][pec_pkg::C_SIMD_FMA]     = s.valid & s.simd & s.fma_op;
            assign slot_hit[g][pec_pkg::C_PREFIX_ONE]   = s.valid & s.prefix_form_one;
            assign slot_hit[g][pec_pkg::C_PREFIX_TWO]   = s.valid & s.prefix_form_two;
            assign slot_hit[g][pec_pkg::C_UNPACK_ONE]   = s.valid & s.prefix_form_one
                                                          & s.unpacked;
            assign slot_hit[g][pec_pkg::C_UNPACK_TWO]   = s.valid & s.prefix_form_two
                                                          & s.unpacked;
            assign slot_hit[g][pec_pkg::C_INT_MAD]      = s.valid & (s.int_multiply_add_low
                                                          | s.int_multiply_add_high);
            assign slot_hit[g][pec_pkg::C_INT_LOAD]     = s.valid & s.int_load
                                                          & ~s.atomic;
            assign slot_hit[g][pec_pkg::C_INT_STORE]    = s.valid & (s.int_store
                                                          | s.atomic);
            assign slot_hit[g][pec_pkg::C_FP_LOAD]      = s.valid & s.fp_load & ~s.simd
                                                          & ~s.quad;
            assign slot_hit[g][pec_pkg::C_FP_STORE]     = s.valid & s.fp_store & ~s.simd
                                                          & ~s.quad;
            assign slot_hit[g][pec_pkg::C_SIMD_FP_LOAD] = s.valid & s.fp_load & s.simd
                                                          & ~s.quad;
            assign slot_hit[g][pec_pkg::C_SIMD_FP_STORE] = s.valid & s.fp_store & s.simd
                                                          & ~s.quad;

            // Packed prefixes ride inside their host and add no flow
            assign slot_flows[g] = (s.valid & ~packed_prefix) ? s.flows
                                                              : '0;

            assign slot_phantom[g] = front.pred_valid[g] & front.pred_taken[g]
                                     & ~front.is_branch[g];
        end
    endgenerate

    // Sum slot hits into per-cycle increments
    always_comb begin
        commit_inc_d  = '0;
        flow_inc_d    = '0;
        phantom_inc_d = '0;
        for (int i = 0; i < pec_pkg::SLOTS; i++) begin
            for (int c = 0; c < pec_pkg::C_N; c++) begin
                commit_inc_d[c] = commit_inc_d[c]
                                  + {{(pec_pkg::CNT_W-1){1'b0}}, slot_hit[i][c]};
            end
            flow_inc_d    = flow_inc_d
                            + {{(pec_pkg::FLOW_SUM_W-pec_pkg::FLOW_W){1'b0}}, slot_flows[i]};
            phantom_inc_d = phantom_inc_d
                            + {{(pec_pkg::CNT_W-1){1'b0}}, slot_phantom[i]};
        end
    end

    // Commit-stall classification of the oldest uncommitted instruction
    always_comb begin
        no_commit = 1'b1;
        for (int i = 0; i < pec_pkg::SLOTS; i++) begin
            if (commit_slot[i].valid) begin
                no_commit = 1'b0;
            end
        end
    end

    // Stores waiting for data are left out, atomics stay in
    assign mem_wait = no_commit & ~oldest.cse_empty & oldest.is_mem & oldest.waiting_data
                      & (~oldest.is_store | oldest.is_atomic);
    assign port_busy_wait = mem_wait & oldest.port_busy;
    assign exec_wait = no_commit & ~oldest.cse_empty & ~oldest.is_mem
                       & (oldest.is_int | oldest.is_fp);

    always_comb begin
        event_d = '0;

        event_d[pec_pkg::E_HOLD_EMPTY] = (front.hold_entries == '0);
        event_d[pec_pkg::E_HALT]       = ctrl.halt_trap | ctrl.halt_priv_update
                                         | ctrl.halt_mem_order | ctrl.halt_hw_retry;
        event_d[pec_pkg::E_FLUSH]      = ctrl.mispredict_flush;

        // Dynamic stalls stay out of the static decode interlock
        event_d[pec_pkg::E_SYNC_ILK]   = front.sync_ilk;
        event_d[pec_pkg::E_REGWIN_ILK] = front.regwin_ilk;
        event_d[pec_pkg::E_DECODE_ILK] = front.sync_ilk | front.regwin_ilk
                                         | front.other_static_ilk;
        event_d[pec_pkg::E_FP_MIX_ILK] = front.fp_mix_ilk;

        event_d[pec_pkg::E_MEM_WAIT]      = mem_wait;
        event_d[pec_pkg::E_MW_NONCACHE]   = mem_wait & oldest.noncacheable;
        event_d[pec_pkg::E_MW_INT]        = mem_wait & oldest.is_int;
        event_d[pec_pkg::E_MW_L2MISS]     = mem_wait & oldest.l2_miss;
        event_d[pec_pkg::E_MW_L2MISS_INT] = mem_wait & oldest.l2_miss & oldest.is_int
                                            & ~oldest.is_store & ~oldest.sw_prefetch;
        // Strong prefetch lands in both the port-busy and the prefetch event
        event_d[pec_pkg::E_MW_PORT_BUSY]  = port_busy_wait & (~oldest.sw_prefetch
                                            | oldest.strong_prefetch);
        event_d[pec_pkg::E_MW_PORT_INT]   = port_busy_wait & oldest.is_int
                                            & ~oldest.sw_prefetch;
        event_d[pec_pkg::E_MW_SW_PF]      = port_busy_wait & oldest.sw_prefetch;

        event_d[pec_pkg::E_CSE_EMPTY]     = no_commit & oldest.cse_empty;
        event_d[pec_pkg::E_CSE_EMPTY_SPF] = no_commit & oldest.cse_empty
                                            & oldest.store_ports_full;

        event_d[pec_pkg::E_EXEC_WAIT]   = exec_wait;
        event_d[pec_pkg::E_BRANCH_WAIT] = no_commit & ~oldest.cse_empty & ~oldest.is_mem
                                          & oldest.is_branch & ~exec_wait;

        // Issue width, clipped at four so exactly one bucket fires
        for (int w = 0; w <= 4; w++) begin
            if (front.issue_cnt > pec_pkg::MAX_ISSUE) begin
                event_d[pec_pkg::E_ISSUE0 + w] = (w == 4);
            end else begin
                event_d[pec_pkg::E_ISSUE0 + w] =
                    (front.issue_cnt == w[pec_pkg::CNT_W-1:0]);
            end
        end

        event_d[pec_pkg::E_TRAP_VECTOR]  = trap_taken.int_vector;
        event_d[pec_pkg::E_TRAP_LEVEL]   = trap_taken.int_level;
        event_d[pec_pkg::E_TRAP_SPILL]   = trap_taken.spill_normal
                                           | trap_taken.spill_other;
        event_d[pec_pkg::E_TRAP_FILL]    = trap_taken.fill_normal
                                           | trap_taken.fill_other;
        event_d[pec_pkg::E_TRAP_INST]    = trap_taken.trap_inst;
        event_d[pec_pkg::E_TRAP_IMISS]   = trap_taken.immu_miss;
        event_d[pec_pkg::E_TRAP_DMISS]   = trap_taken.dmmu_miss;
        event_d[pec_pkg::E_TRAP_SIMD_PG] = trap_taken.simd_cross_page;
        event_d[pec_pkg::E_TRAP_ALL]     = |trap_taken;
    end

    // Commit-side increments
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            commit_inc_q <= '0;
            flow_inc_q   <= '0;
        end else begin
            commit_inc_q <= commit_inc_d;
            flow_inc_q   <= flow_inc_d;
        end
    end

    // Front-end phantom branch count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phantom_inc_q <= '0;
        end else begin
            phantom_inc_q <= phantom_inc_d;
        end
    end

    // Single-cycle events
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            event_q <= '0;
        end else begin
            event_q <= event_d;
        end
    end

    assign commit_inc  = commit_inc_q;
    assign flow_inc    = flow_inc_q;
    assign phantom_inc = phantom_inc_q;
    assign event_hit   = event_q;

endmodule : pec_event_gen

`default_nettype wire

// file: tb/pec_event_gen_chk.sv
// Concurrent checks of event generator outputs against the sampled pipeline state
`timescale 1ns/1ps
`default_nettype none

module pec_event_gen_chk (
    input wire logic                                           clk,
    input wire logic                                           resetn,
    input wire pec_pkg::pec_commit_slot_t [pec_pkg::SLOTS-1:0] commit_slot,
    input wire pec_pkg::pec_trap_t                             trap_taken,
    input wire pec_pkg::pec_front_t                            front,
    input wire pec_pkg::pec_ctrl_t                             ctrl,
    input wire pec_pkg::pec_oldest_t                           oldest,
    input wire logic [pec_pkg::C_N-1:0][pec_pkg::CNT_W-1:0]    commit_inc,
    input wire logic [pec_pkg::FLOW_SUM_W-1:0]                 flow_inc,
    input wire logic [pec_pkg::CNT_W-1:0]                      phantom_inc,
    input wire logic [pec_pkg::E_N-1:0]                        event_hit
);
    logic any_commit;

    assign any_commit = commit_slot[0].valid | commit_slot[1].valid
                      | commit_slot[2].valid | commit_slot[3].valid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_trap_all_sum: assert property (1'b1 |=>
        event_hit[pec_pkg::E_TRAP_ALL] == $past(|trap_taken))
        else $error("trap total differs from trap inputs");
    a_flush_once: assert property (ctrl.mispredict_flush ##1 !ctrl.mispredict_flush
        |-> event_hit[pec_pkg::E_FLUSH] ##1 !event_hit[pec_pkg::E_FLUSH])
        else $error("flush event not a single count");
    a_halt_causes: assert property (1'b1 |=> event_hit[pec_pkg::E_HALT] ==
        $past(ctrl.halt_trap | ctrl.halt_priv_update | ctrl.halt_mem_order | ctrl.halt_hw_retry))
        else $error("halt event wrong");
    a_issue_onehot: assert property (1'b1 |=> $onehot(event_hit[pec_pkg::E_ISSUE0 +: 5]))
        else $error("issue buckets not one-hot");
    a_issue_clip_four: assert property (front.issue_cnt > pec_pkg::MAX_ISSUE
        |=> event_hit[pec_pkg::E_ISSUE0 + 4])
        else $error("issue above four not in top bucket");
    a_hold_empty: assert property (1'b1 |=> event_hit[pec_pkg::E_HOLD_EMPTY] ==
        ($past(front.hold_entries) == 3'h0))
        else $error("holding register empty event wrong");
    a_decode_ilk_set: assert property (1'b1 |=> event_hit[pec_pkg::E_DECODE_ILK] ==
        $past(front.sync_ilk | front.regwin_ilk | front.other_static_ilk))
        else $error("static interlock event wrong");
    a_mem_wait_sub: assert property (
        (|event_hit[pec_pkg::E_MW_SW_PF:pec_pkg::E_MW_NONCACHE])
        |-> event_hit[pec_pkg::E_MEM_WAIT])
        else $error("memory wait subcategory without memory wait");
    a_stall_no_commit: assert property (any_commit
        |=> !event_hit[pec_pkg::E_MEM_WAIT]
        && !event_hit[pec_pkg::E_CSE_EMPTY] && !event_hit[pec_pkg::E_EXEC_WAIT]
        && !event_hit[pec_pkg::E_BRANCH_WAIT])
        else $error("commit stall counted in a commit cycle");
    a_exec_over_branch: assert property (!any_commit && !oldest.cse_empty
        && !oldest.is_mem && (oldest.is_int || oldest.is_fp)
        |=> event_hit[pec_pkg::E_EXEC_WAIT] && !event_hit[pec_pkg::E_BRANCH_WAIT])
        else $error("branch wait counted with execution wait");
    a_cse_spf_sub: assert property (event_hit[pec_pkg::E_CSE_EMPTY_SPF]
        |-> event_hit[pec_pkg::E_CSE_EMPTY])
        else $error("port-full stall without empty stack");
endmodule : pec_event_gen_chk

bind pec_event_gen pec_event_gen_chk u_chk (.clk(clk), .resetn(resetn),
    .commit_slot(commit_slot), .trap_taken(trap_taken), .front(front), .ctrl(ctrl),
    .oldest(oldest), .commit_inc(commit_inc), .flow_inc(flow_inc),
    .phantom_inc(phantom_inc), .event_hit(event_hit));

`default_nettype wire

// file: tb/pec_event_gen_tb_top.sv
// Self-checking bench for the performance event generator
`timescale 1ns/1ps
`default_nettype none

module pec_event_gen_tb_top;
    logic                                           clk;
    logic                                           resetn;
    pec_pkg::pec_commit_slot_t [pec_pkg::SLOTS-1:0] cs;
    pec_pkg::pec_trap_t                             trap_taken;
    pec_pkg::pec_front_t                            front;
    pec_pkg::pec_ctrl_t                             ctrl;
    pec_pkg::pec_oldest_t                           oldest;
    logic [pec_pkg::C_N-1:0][pec_pkg::CNT_W-1:0]    ci;
    logic [pec_pkg::FLOW_SUM_W-1:0]                 flow_inc;
    logic [pec_pkg::CNT_W-1:0]                      phantom_inc;
    logic [pec_pkg::E_N-1:0]                        eh;
    int                                             err_count;
    int                                             n_tests;

    pec_event_gen DUT (.clk(clk), .resetn(resetn), .commit_slot(cs), .trap_taken(trap_taken),
        .front(front), .ctrl(ctrl), .oldest(oldest), .commit_inc(ci), .flow_inc(flow_inc),
        .phantom_inc(phantom_inc), .event_hit(eh));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask : check

    task automatic clr();
        cs = '0;
        trap_taken = '0;
        front = '0;
        ctrl = '0;
        oldest = '0;
    endtask : clr

    // Inputs land one step after the edge; outputs are read one step after the next edge
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic all_valid();
        clr();
        for (int i = 0; i < 4; i++) cs[i].valid = 1'b1;
    endtask : all_valid

    task automatic t_simd();
        all_valid();
        for (int i = 0; i < 4; i++) begin
            cs[i].simd = 1'b1;
            cs[i].fp_op = (i < 2);
            cs[i].fma_op = (i >= 2);
        end
        cs[3].valid = 1'b0;
        cs[0].int_multiply_add_low = 1'b1;
        cs[1].int_multiply_add_high = 1'b1;
        step();
        check("simd_fp", 32'(ci[pec_pkg::C_SIMD_FP]), 32'h2);
        check("simd_fma", 32'(ci[pec_pkg::C_SIMD_FMA]), 32'h1);
        check("int_mad", 32'(ci[pec_pkg::C_INT_MAD]), 32'h2);
    endtask : t_simd

    task automatic t_prefix();
        all_valid();
        for (int i = 0; i < 4; i++) cs[i].flows = (i == 3) ? 3'h3 : 3'h1;
        cs[0].prefix_form_one = 1'b1;
        cs[1].prefix_form_one = 1'b1;
        cs[1].unpacked = 1'b1;
        cs[2].prefix_form_two = 1'b1;
        cs[2].unpacked = 1'b1;
        step();
        check("pfx_one", 32'(ci[pec_pkg::C_PREFIX_ONE]), 32'h2);
        check("pfx_two", 32'(ci[pec_pkg::C_PREFIX_TWO]), 32'h1);
        check("unp_one", 32'(ci[pec_pkg::C_UNPACK_ONE]), 32'h1);
        check("unp_two", 32'(ci[pec_pkg::C_UNPACK_TWO]), 32'h1);
        check("flows", 32'(flow_inc), 32'h5);
    endtask : t_prefix

    task automatic t_ldst();
        all_valid();
        cs[0].int_load = 1'b1;
        cs[1].int_store = 1'b1;
        cs[2].int_load = 1'b1;
        cs[2].atomic = 1'b1;
        cs[3].int_load = 1'b1;
        step();
        check("int_ld", 32'(ci[pec_pkg::C_INT_LOAD]), 32'h2);
        check("int_st", 32'(ci[pec_pkg::C_INT_STORE]), 32'h2);
        all_valid();
        cs[0].fp_load = 1'b1;
        cs[1].fp_load = 1'b1;
        cs[1].quad = 1'b1;
        cs[2].fp_load = 1'b1;
        cs[2].simd = 1'b1;
        cs[3].fp_store = 1'b1;
        cs[3].simd = 1'b1;
        step();
        check("fp_ld", 32'(ci[pec_pkg::C_FP_LOAD]), 32'h1);
        check("fp_st", 32'(ci[pec_pkg::C_FP_STORE]), 32'h0);
        check("simd_ld", 32'(ci[pec_pkg::C_SIMD_FP_LOAD]), 32'h1);
        check("simd_st", 32'(ci[pec_pkg::C_SIMD_FP_STORE]), 32'h1);
    endtask : t_ldst

    task automatic t_traps();
        int idx [10] = '{1, 2, 3, 3, 4, 4, 5, 6, 7, 8};
        clr();
        for (int i = 0; i < 10; i++) begin
            trap_taken = pec_pkg::pec_trap_t'(10'h200 >> i);
            step();
            check("trap", 32'(eh[pec_pkg::E_TRAP_SIMD_PG:pec_pkg::E_TRAP_ALL]),
                  32'h1 | (32'h1 << idx[i]));
        end
    endtask : t_traps

    task automatic t_front();
        clr();
        for (int w = 0; w < 6; w++) begin
            front.issue_cnt = 3'(w);
            front.hold_entries = 3'(w);
            step();
            check("issue", 32'(eh[pec_pkg::E_ISSUE0 +: 5]), 32'h1 << ((w > 4) ? 4 : w));
            check("hold_empty", 32'(eh[pec_pkg::E_HOLD_EMPTY]), 32'(w == 0));
        end
        for (int k = 0; k < 4; k++) begin
            {front.sync_ilk, front.regwin_ilk, front.other_static_ilk,
             front.dynamic_stall} = 4'h8 >> k;
            front.fp_mix_ilk = (k == 2);
            step();
            check("sync_ilk", 32'(eh[pec_pkg::E_SYNC_ILK]), 32'(k == 0));
            check("regwin_ilk", 32'(eh[pec_pkg::E_REGWIN_ILK]), 32'(k == 1));
            check("decode_ilk", 32'(eh[pec_pkg::E_DECODE_ILK]), 32'(k < 3));
            check("fp_mix", 32'(eh[pec_pkg::E_FP_MIX_ILK]), 32'(k == 2));
        end
        front.pred_valid = 4'he;
        front.pred_taken = 4'hb;
        front.is_branch = 4'h2;
        step();
        check("phantom", 32'(phantom_inc), 32'h1);
    endtask : t_front

    task automatic t_ctrl();
        clr();
        for (int h = 0; h < 4; h++) begin
            ctrl = pec_pkg::pec_ctrl_t'(5'h10 >> h);
            step();
            check("halt", 32'(eh[pec_pkg::E_HALT]), 32'h1);
        end
        ctrl = pec_pkg::pec_ctrl_t'(5'h01);
        step();
        check("flush", 32'(eh[pec_pkg::E_FLUSH]), 32'h1);
        check("halt_off", 32'(eh[pec_pkg::E_HALT]), 32'h0);
        ctrl = '0;
        step();
        check("flush_off", 32'(eh[pec_pkg::E_FLUSH]), 32'h0);
    endtask : t_ctrl

    task automatic t_stall();
        logic [13:0] cfg [9] = '{14'h0c48, 14'h0e40, 14'h0f80, 14'h0c07, 14'h0c44,
                                 14'h3000, 14'h0050, 14'h0010, 14'h0c48};
        logic [11:0] want [9] = '{12'h01d, 12'h000, 12'h003, 12'h0a1, 12'h065,
                                  12'h300, 12'h400, 12'h800, 12'h000};
        logic [11:0] got;
        clr();
        for (int i = 0; i < 9; i++) begin
            oldest = pec_pkg::pec_oldest_t'(cfg[i]);
            cs[0].valid = (i == 8);
            step();
            got = eh[pec_pkg::E_BRANCH_WAIT:pec_pkg::E_MEM_WAIT];
            check("stall", 32'(got), 32'(want[i]));
        end
    endtask : t_stall

    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        err_count = 0;
        n_tests = 0;
        resetn = 1'b0;
        clr();
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_simd();
        t_prefix();
        t_ldst();
        t_traps();
        t_front();
        t_ctrl();
        t_stall();
        print_verdict();
    end
endmodule : pec_event_gen_tb_top

`default_nettype wire
